// ---- src/irt_pkg.sv ----
// package: register map, field layout and types for the event/remap register slice
package irt_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_EV_DATA = 8'hA4;
	localparam logic [ADDR_W-1:0] OFF_EV_ADDR = 8'hA8;
	localparam logic [ADDR_W-1:0] OFF_EV_UADDR = 8'hAC;
	localparam logic [ADDR_W-1:0] OFF_RT_LO = 8'hB8;
	localparam logic [ADDR_W-1:0] OFF_RT_HI = 8'hBC;
	localparam logic [ADDR_W-1:0] OFF_EV_CTRL = 8'hA0;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'hF0;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'hF4;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] DATA_LO_MASK = 32'h0000_FFFF;
	localparam logic [31:0] ADDR_LO_MASK = 32'hFFFF_FFFC;
	localparam logic [31:0] RT_LO_MASK = 32'hFFFF_F80F;
	localparam logic [31:0] RT_BASE_LO_MASK = 32'hFFFF_F000;
	localparam int unsigned WIDE_EN_BIT = 11;
	localparam int unsigned SIZE_W = 4;
	localparam int unsigned MASK_BIT = 31;
	localparam int unsigned PEND_BIT = 30;
	localparam int unsigned ENTRY_W = 17;
	localparam logic [ENTRY_W-1:0] ENTRY_ONE = 17'h00001;
	localparam int unsigned DEST_W = 32;
	localparam int unsigned DEST_NARROW_HI = 15;
	localparam int unsigned DEST_NARROW_LO = 8;
	localparam int unsigned NUM_IRQ = 2;
	localparam int unsigned IRQ_SENT = 0;
	localparam int unsigned IRQ_BADWR = 1;

	typedef struct packed {
		logic [31:0] addr_hi;
		logic [31:0] addr_lo;
		logic [31:0] data;
	} irt_msg_t;

	typedef struct packed {
		logic [63:0] base;
		logic wide_en;
		logic [ENTRY_W-1:0] entries;
	} irt_table_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEND
	} irt_state_t;
endpackage

// ---- src/irt_regs.sv ----
// module: event message and remap table register slice with APB slave
//
// Function
// - low message data bits 15:0 are read-write and carried into the event message data.
// - upper message data bits 31:16 only exist with 32-bit data support, else read zero.
// - message low address bits 31:2 are read-write and form the message address; bits 1:0 read zero.
// - with queued invalidation and wide mode the upper address register is a full 32-bit read-write word.
// - without either capability the upper address register reads zero and drops writes.
// - without queued invalidation the event data and address registers read zero and drop writes.
// - without remapping support the table register reads zero and drops writes.
// - the table base lives in bits 63:12, so the table is 4KB aligned.
// - base bits at or above the host address width are not stored.
// - a read of the base bits below the host address width returns what software last wrote to them.
// - with wide destination clear, only destination bits 15:8 are used.
// - with wide destination set, all 32 destination bits are used.
// - without wide capability the wide destination enable reads zero and drops writes.
// - a four-bit size X gives two to the power X+1 table entries.
// - an event with the mask clear sends a message built from the data and address registers.
// - the mask resets set and no message goes out while it is set.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module irt_regs #(
	parameter bit QI_SUP = 1'b1,
	parameter bit IR_SUP = 1'b1,
	parameter bit WIDE_SUP = 1'b1,
	parameter bit DATA32_SUP = 1'b1,
	parameter int unsigned HOST_AW = 48
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic inval_event,
	input wire logic [irt_pkg::DEST_W-1:0] entry_dest_in,
	output logic [irt_pkg::DEST_W-1:0] entry_dest_out,
	output irt_pkg::irt_msg_t msg_out,
	output logic msg_valid,
	input wire logic msg_ready,
	output irt_pkg::irt_table_t table_cfg,
	output logic irq
);
	import irt_pkg::*;

	// ----------------------------------------
	// capability derived masks
	// ----------------------------------------
	localparam logic [31:0] DATA_MASK = !QI_SUP ? RST_ZERO :
		(DATA32_SUP ? ~RST_ZERO : DATA_LO_MASK);
	localparam logic [31:0] ADDR_MASK = QI_SUP ? ADDR_LO_MASK : RST_ZERO;
	localparam logic [31:0] UADDR_MASK = (QI_SUP && WIDE_SUP) ? ~RST_ZERO : RST_ZERO;
	localparam logic [63:0] HAW_MASK = (HOST_AW >= 64) ? ~64'h0 : ((64'h1 << HOST_AW) - 64'h1);
	localparam logic [63:0] RT_MASK_FULL = {HAW_MASK[63:32], HAW_MASK[31:0] & RT_LO_MASK};
	localparam logic [63:0] RT_MASK_WIDE = WIDE_SUP ? RT_MASK_FULL :
		(RT_MASK_FULL & ~(64'h1 << WIDE_EN_BIT));
	localparam logic [63:0] RT_MASK = IR_SUP ? RT_MASK_WIDE : 64'h0;

	logic [31:0] data_q;
	logic [31:0] addr_q;
	logic [31:0] uaddr_q;
	logic [63:0] rt_q;
	logic mask_q;
	logic pend_q;
	logic [NUM_IRQ-1:0] stat_q;
	logic [NUM_IRQ-1:0] imask_q;
	irt_state_t state_q;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic acc;
	logic acc_req;
	logic wr;
	logic rd_req;
	logic [ADDR_W-1:0] off;
	logic hit;
	logic [31:0] bmask;
	assign acc_req = psel && penable && !pready;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && hit;
	assign rd_req = acc_req && !pwrite;
	assign off = paddr[ADDR_W-1:0];
	assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	always_comb begin
		case (off)
			OFF_EV_DATA, OFF_EV_ADDR, OFF_EV_UADDR, OFF_RT_LO, OFF_RT_HI,
			OFF_EV_CTRL, OFF_IRQ_STAT, OFF_IRQ_MASK: hit = (paddr[31:ADDR_W] == '0);
			default: hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// write strobes, one per register
	// ----------------------------------------
	logic wr_data;
	logic wr_addr;
	logic wr_uaddr;
	logic wr_rt_lo;
	logic wr_rt_hi;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_imask;
	assign wr_data = wr && off == OFF_EV_DATA;
	assign wr_addr = wr && off == OFF_EV_ADDR;
	assign wr_uaddr = wr && off == OFF_EV_UADDR;
	assign wr_rt_lo = wr && off == OFF_RT_LO;
	assign wr_rt_hi = wr && off == OFF_RT_HI;
	assign wr_ctrl = wr && off == OFF_EV_CTRL;
	assign wr_stat = wr && off == OFF_IRQ_STAT;
	assign wr_imask = wr && off == OFF_IRQ_MASK;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] bm, input logic [31:0] keep);
		merge = ((old & ~bm) | (nw & bm)) & keep;
	endfunction

	// ----------------------------------------
	// apb handshake, one wait state
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= acc_req;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= acc_req && !hit;
		end
	end

	// ----------------------------------------
	// read data, unmapped reads return zero
	// ----------------------------------------
	logic [31:0] ctrl_rd;
	always_comb begin
		ctrl_rd = RST_ZERO;
		ctrl_rd[MASK_BIT] = mask_q && QI_SUP;
		ctrl_rd[PEND_BIT] = pend_q && QI_SUP;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prdata <= RST_ZERO;
		end else if (rd_req && !hit) begin
			prdata <= RST_ZERO;
		end else if (rd_req) begin
			case (off)
				OFF_EV_DATA: prdata <= data_q;
				OFF_EV_ADDR: prdata <= addr_q;
				OFF_EV_UADDR: prdata <= uaddr_q;
				OFF_RT_LO: prdata <= rt_q[31:0];
				OFF_RT_HI: prdata <= rt_q[63:32];
				OFF_EV_CTRL: prdata <= ctrl_rd;
				OFF_IRQ_STAT: prdata <= {{(32-NUM_IRQ){1'b0}}, stat_q};
				OFF_IRQ_MASK: prdata <= {{(32-NUM_IRQ){1'b0}}, imask_q};
				default: prdata <= RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// message registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			data_q <= RST_ZERO;
		end else if (wr_data) begin
			data_q <= merge(data_q, pwdata, bmask, DATA_MASK);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_q <= RST_ZERO;
		end else if (wr_addr) begin
			addr_q <= merge(addr_q, pwdata, bmask, ADDR_MASK);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			uaddr_q <= RST_ZERO;
		end else if (wr_uaddr) begin
			uaddr_q <= merge(uaddr_q, pwdata, bmask, UADDR_MASK);
		end
	end

	// ----------------------------------------
	// remap table register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rt_q <= 64'h0;
		end else if (wr_rt_lo) begin
			rt_q[31:0] <= merge(rt_q[31:0], pwdata, bmask, RT_MASK[31:0]);
		end else if (wr_rt_hi) begin
			rt_q[63:32] <= merge(rt_q[63:32], pwdata, bmask, RT_MASK[63:32]);
		end
	end

	// ----------------------------------------
	// table config output
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			table_cfg <= '0;
		end else begin
			table_cfg.base <= rt_q & RT_BASE_MASK64();
			table_cfg.wide_en <= rt_q[WIDE_EN_BIT];
			table_cfg.entries <= ENTRY_W'(ENTRY_ONE << (rt_q[SIZE_W-1:0] + 5'd1));
		end
	end

	function automatic logic [63:0] RT_BASE_MASK64();
		RT_BASE_MASK64 = {32'hFFFF_FFFF, RT_BASE_LO_MASK};
	endfunction

	// ----------------------------------------
	// destination interpretation of a table entry
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			entry_dest_out <= '0;
		end else if (rt_q[WIDE_EN_BIT]) begin
			entry_dest_out <= entry_dest_in;
		end else begin
			entry_dest_out <= '0;
			entry_dest_out[DEST_NARROW_HI:DEST_NARROW_LO] <= entry_dest_in[DEST_NARROW_HI:DEST_NARROW_LO];
		end
	end

	// ----------------------------------------
	// event control, mask and pending
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mask_q <= 1'b1;
		end else if (wr_ctrl && pstrb[3] && QI_SUP) begin
			mask_q <= pwdata[MASK_BIT];
		end
	end

	// ----------------------------------------
	// pending flag
	// ----------------------------------------
	logic send;
	assign send = state_q == ST_IDLE && pend_q && !mask_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (inval_event && QI_SUP) begin
			pend_q <= 1'b1;
		end else if (send) begin
			pend_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// message sender
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: if (send) begin
					state_q <= ST_SEND;
				end
				ST_SEND: if (msg_ready) begin
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// message output register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			msg_valid <= 1'b0;
			msg_out <= '0;
		end else if (send) begin
			msg_valid <= 1'b1;
			msg_out.addr_hi <= uaddr_q;
			msg_out.addr_lo <= addr_q & ADDR_LO_MASK;
			msg_out.data <= data_q;
		end else if (state_q == ST_SEND && msg_ready) begin
			msg_valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [NUM_IRQ-1:0] ev;
	always_comb begin
		ev = '0;
		ev[IRQ_SENT] = state_q == ST_SEND && msg_ready;
		ev[IRQ_BADWR] = acc_req && !hit;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stat_q <= '0;
		end else if (wr_stat) begin
			stat_q <= (stat_q & ~pwdata[NUM_IRQ-1:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	// ----------------------------------------
	// interrupt mask
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			imask_q <= '0;
		end else if (wr_imask) begin
			imask_q <= pwdata[NUM_IRQ-1:0];
		end
	end

	// ----------------------------------------
	// interrupt output
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & imask_q);
		end
	end
endmodule // irt_regs

// ---- verification/irt_regs_asserts.sv ----
// checker: port assertions for the event and remap register slice
`timescale 1ns/10ps
module irt_regs_chk
	import irt_pkg::*;
#(
	parameter int unsigned HOST_AW = 48
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire irt_pkg::irt_msg_t msg_out,
	input wire irt_pkg::irt_table_t table_cfg,
	input wire logic [31:0] entry_dest_in,
	input wire logic [31:0] entry_dest_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("ready missing");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_unmapped: assert property (pready && paddr[31:8] != 24'h0 |-> pslverr) else $error("no slave error");
	a_addr_aligned: assert property (msg_valid |-> msg_out.addr_lo[1:0] == 2'b00)
		else $error("addr low bits");
	a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_out))
		else $error("msg dropped");
	a_msg_done: assert property (msg_valid && msg_ready |=> !msg_valid)
		else $error("msg not retired");
	a_base_align: assert property (table_cfg.base[11:0] == 12'h000)
		else $error("base unaligned");
	a_base_width: assert property ((table_cfg.base >> HOST_AW) == 64'h0)
		else $error("base too wide");
	a_entries_pow: assert property ($past(rst_n) |-> $onehot(table_cfg.entries) && !table_cfg.entries[0])
		else $error("entry count");
	a_dest_wide: assert property (table_cfg.wide_en && $past(table_cfg.wide_en) && $past(table_cfg.wide_en, 2)
		|-> entry_dest_out == $past(entry_dest_in)) else $error("wide dest");
	a_dest_narrow: assert property (!table_cfg.wide_en && $past(rst_n)
		|-> entry_dest_out == {16'h0000, $past(entry_dest_in[15:8]), 8'h00}) else $error("narrow dest");
endmodule // irt_regs_chk

// ---- verification/testbench.sv ----
// testbench: apb driven checks of the event and remap register slice
`timescale 1ns/10ps
module testbench;
	import irt_pkg::*;
	localparam int AW = 48;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, inval_event, msg_valid, msg_ready, irq, er;
	logic [31:0] paddr, pwdata, prdata, entry_dest_in, entry_dest_out, rd, rd_lo, rd_off, prdata_lo, prdata_off;
	logic [3:0] pstrb;
	irt_msg_t msg_out;
	irt_table_t table_cfg;
	int error_cnt, checked, cyc;
	irt_regs #(.HOST_AW(AW)) dut(.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .inval_event(inval_event), .entry_dest_in(entry_dest_in),
		.entry_dest_out(entry_dest_out), .msg_out(msg_out), .msg_valid(msg_valid), .msg_ready(msg_ready),
		.table_cfg(table_cfg), .irq(irq));
	// narrow data, no wide mode
	irt_regs #(.WIDE_SUP(1'b0), .DATA32_SUP(1'b0), .HOST_AW(AW)) dut_lo(.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata_lo), .pready(), .pslverr(), .inval_event(inval_event), .entry_dest_in(entry_dest_in),
		.entry_dest_out(), .msg_out(), .msg_valid(), .msg_ready(msg_ready), .table_cfg(), .irq());
	// no queued invalidation, no remapping
	irt_regs #(.QI_SUP(1'b0), .IR_SUP(1'b0), .HOST_AW(AW)) dut_off(.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata_off), .pready(), .pslverr(), .inval_event(inval_event), .entry_dest_in(entry_dest_in),
		.entry_dest_out(), .msg_out(), .msg_valid(), .msg_ready(msg_ready), .table_cfg(), .irq());
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		rd_lo = prdata_lo;
		rd_off = prdata_off;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk({er, rd}, {1'b0, exp});
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, inval_event, msg_ready} = 6'h00;
		{paddr, pwdata, entry_dest_in} = {3{32'h0}};
		pstrb = 4'hF;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdc(OFF_EV_CTRL, 32'h8000_0000);
		rdc(OFF_EV_DATA, 32'h0);
		rdc(OFF_EV_ADDR, 32'h0);
		rdc(OFF_EV_UADDR, 32'h0);
		rdc(OFF_RT_LO, 32'h0);
		rdc(OFF_IRQ_MASK, 32'h0);
		$display("test reset done");
		apb(1'b1, OFF_EV_DATA, 32'hCAFE_1234);
		rdc(OFF_EV_DATA, 32'hCAFE_1234);
		chk({rd_lo, rd_off}, {32'h0000_1234, 32'h0000_0000});
		apb(1'b1, OFF_EV_ADDR, 32'h8765_4323);
		rdc(OFF_EV_ADDR, 32'h8765_4320);
		chk({rd_lo, rd_off}, {32'h8765_4320, 32'h0000_0000});
		apb(1'b1, OFF_EV_UADDR, 32'hFFFF_FFFF);
		rdc(OFF_EV_UADDR, 32'hFFFF_FFFF);
		chk({rd_lo, rd_off}, 64'h0);
		apb(1'b1, OFF_RT_LO, 32'hFFFF_FFFF);
		rdc(OFF_RT_LO, RT_LO_MASK);
		chk({rd_lo, rd_off}, {32'hFFFF_F00F, 32'h0000_0000});
		apb(1'b1, OFF_RT_HI, 32'hFFFF_FFFF);
		rdc(OFF_RT_HI, 32'hFFFF_FFFF >> (64 - AW));
		chk(rd_off, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(table_cfg, {32'hFFFF_FFFF >> (64 - AW), 32'hFFFF_F000, 1'b1, 17'h10000});
		entry_dest_in <= 32'h1234_5678;
		repeat (3) @(posedge clk_sys);
		chk(entry_dest_out, 32'h1234_5678);
		for (int s = 0; s < 16; s += 15) begin
			apb(1'b1, OFF_RT_LO, s);
			repeat (2) @(posedge clk_sys);
			chk({table_cfg.wide_en, table_cfg.entries}, {1'b0, 17'h1 << (s + 1)});
		end
		entry_dest_in <= 32'hAAAA_55CC;
		repeat (3) @(posedge clk_sys);
		chk(entry_dest_out, 32'h0000_5500);
		entry_dest_in <= 32'h5555_A633;
		repeat (3) @(posedge clk_sys);
		chk(entry_dest_out, 32'h0000_A600);
		$display("test registers done");
		inval_event <= 1'b1;
		@(posedge clk_sys);
		inval_event <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk(msg_valid, 1'b0);
		rdc(OFF_EV_CTRL, 32'hC000_0000);
		apb(1'b1, OFF_EV_CTRL, 32'h0);
		for (int i = 0; i < 20 && msg_valid !== 1'b1; i++) @(posedge clk_sys);
		chk(msg_out, {32'hFFFF_FFFF, 32'h8765_4320, 32'hCAFE_1234});
		repeat (3) @(posedge clk_sys);
		chk(msg_valid, 1'b1);
		msg_ready <= 1'b1;
		@(posedge clk_sys);
		msg_ready <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(msg_valid, 1'b0);
		rdc(OFF_IRQ_STAT, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'b1);
		apb(1'b1, OFF_IRQ_STAT, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'b0);
		$display("test message done");
		apb(1'b0, 32'h0000_0004, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b0, 32'h0000_01A8, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b1, 32'h0000_01A4, 32'h5);
		chk(er, 1'b1);
		rdc(OFF_EV_DATA, 32'hCAFE_1234);
		rdc(OFF_IRQ_STAT, 32'h2);
		$display("test unmapped done");
		report_and_stop();
	end
endmodule // testbench
bind irt_regs irt_regs_chk #(.HOST_AW(HOST_AW)) u_chk(.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
	.msg_ready(msg_ready), .msg_out(msg_out), .table_cfg(table_cfg), .entry_dest_in(entry_dest_in),
	.entry_dest_out(entry_dest_out));
